// ===== hw/swc_map.svh
// Register offsets, reset values and field positions of the sleep and wake controller
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_W          4
`define SWC_OFF_FLAGS       4'h0
`define SWC_OFF_ENABLE      4'h1
`define SWC_OFF_OSCSEL      4'h2
`define SWC_OFF_CTRL        4'h3
`define SWC_OFF_STATUS      4'h4
`define SWC_OFF_IRQ_STAT    4'h5
`define SWC_OFF_IRQ_MASK    4'h6
`define SWC_FLAGS_RST       8'h00
`define SWC_OSC_RST         3'h0
`define SWC_CTRL_HOLD_BIT   0
`define SWC_CTRL_GIE_BIT    1
`define SWC_CTRL_BOREN_BIT  2
`define SWC_CTRL_MCLREN_BIT 3
`define SWC_CTRL_WDTEN_BIT  4
`define SWC_ST_TO_BIT       0
`define SWC_ST_PD_BIT       1
`define SWC_ST_DONE_BIT     2
`define SWC_EV_WAKE_BIT     0
`define SWC_EV_SWITCH_BIT   1
`define SWC_EV_NOPSLP_BIT   2
`define SWC_PC_STEP         16'h0002
`endif

// ===== hw/swc_pkg.sv
// Types shared by the sleep and wake controller
package swc_pkg;
    typedef enum logic [2:0] {
        SWC_RUN,
        SWC_SWITCHING,
        SWC_SLEEP,
        SWC_READY_WAIT,
        SWC_VECTOR
    } swc_state_t;
    typedef enum logic [1:0] {
        SWC_WAKE_NONE,
        SWC_WAKE_RESET,
        SWC_WAKE_IRQ
    } swc_wake_t;
endpackage : swc_pkg

// ===== hw/swc_ready_gate.sv
// Readiness gate: flash, oscillator and brown-out ready before execution resumes
`timescale 1ns/1ps
`default_nettype none
module swc_ready_gate (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_flash_ready,
    input  wire logic i_osc_ready,
    input  wire logic i_bor_ready,
    input  wire logic i_bor_enable,
    output logic      o_all_ready
);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_all_ready <= 1'b0;
        end else begin
            // Brown-out term drops out when brown-out reset is off
            o_all_ready <= i_flash_ready && i_osc_ready && (i_bor_ready || !i_bor_enable);
        end
    end
endmodule : swc_ready_gate
`default_nettype wire

// ===== hw/swc_ctrl.sv
// Sleep and wake controller with peripheral event flags and register port
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
// Functional notes
// - A new oscillator selection still pending when sleep is entered is abandoned and sleep is entered.
// - Waking by interrupt with the switch hold bit clear runs from the new clock and sets the switch done flag.
// - Waking by interrupt with the switch hold bit set keeps the old clock and requests the new one again; a reset wake drops the request.
// - The new oscillator ready indication is a one-cycle pulse when a switch completes, hold bit clear, in a cycle without a sleep; not on a wake from sleep.
// - Each peripheral event sets its flag in hardware regardless of enables; only software clears it.
// - Reset pin, brown-out, low-power brown-out, power-on and watchdog wake by reset; an enabled interrupt wakes and resumes.
// - The clock switch interrupt never wakes the device, nor do the wake and no-op sleep events; enabled peripheral flags may.
// - During sleep the instruction at the program counter plus two is prefetched.
// - An interrupt wakes only when its enable and flag are both set, whatever the global enable.
// - With global interrupts off execution continues after sleep; with them on it runs that instruction then vectors.
// - The watchdog is cleared on every wake from sleep.
// - Execution resumes only once flash, oscillator and (if enabled) brown-out logic are ready.
// - With an enabled interrupt already pending, sleep is a no-operation and watchdog, timeout and power-down stay as they were.
// - An interrupt arriving during or after sleep completes the sleep, wakes at once, clears the watchdog, sets timeout, clears power-down.
module swc_ctrl
    import swc_pkg::*;
#(
    parameter int unsigned SWITCH_CYCLES = 4,
    parameter int unsigned PC_W          = 16
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  wire logic [`SWC_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [7:0]             o_rdata,
    input  wire logic                   i_sleep_exec,
    input  wire logic [PC_W-1:0]        i_pc,
    input  wire logic [7:0]             i_event,
    input  wire logic                   i_reset_pin,
    input  wire logic                   i_bor_trip,
    input  wire logic                   i_low_power_brownout_reset_trip,
    input  wire logic                   i_por,
    input  wire logic                   i_wdt_expire,
    input  wire logic                   i_flash_ready,
    input  wire logic                   i_osc_ready,
    input  wire logic                   i_bor_ready,
    output logic                        o_sleeping,
    output logic                        o_core_run,
    output logic                        o_vector_req,
    output logic                        o_reset_req,
    output logic                        o_wdt_clear,
    output logic      [PC_W-1:0]        o_prefetch_pc,
    output logic                        o_prefetch_req,
    output logic      [2:0]             o_clk_sel,
    output logic                        o_new_osc_ready,
    output logic                        o_irq
);
    initial begin
        if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) $error("SWITCH_CYCLES out of range");
        if (PC_W < 2) $error("PC_W too small");
    end

    function automatic logic bitv(input logic [7:0] v, input int unsigned pos);
        return v[pos[2:0]];
    endfunction : bitv

    swc_state_t  state_q;
    logic [7:0]  flags_q;
    logic [7:0]  enable_q;
    logic [2:0]  osc_req_q;
    logic [2:0]  osc_cur_q;
    logic [7:0]  ctrl_q;
    logic        to_q;
    logic        pd_q;
    logic        sw_done_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_mask_q;
    logic [7:0]  sw_cnt_q;
    logic        sw_pending_q;
    logic        rst_wake_q;
    logic        all_ready;
    logic        wr_flags;
    logic        wr_osc;
    logic        rd_irq;
    logic        irq_pending;
    logic        reset_wake;
    logic        wake_irq;
    logic        ev_wake;
    logic        ev_switch;
    logic        ev_nop_sleep;

    assign wr_flags    = i_wr && (i_addr == `SWC_OFF_FLAGS);
    assign wr_osc      = i_wr && (i_addr == `SWC_OFF_OSCSEL);
    assign rd_irq      = i_rd && (i_addr == `SWC_OFF_IRQ_STAT);
    // Only peripheral sources count; the switch done flag is never part of this wake term
    assign irq_pending = |(flags_q & enable_q);
    assign reset_wake  = i_reset_pin && bitv(ctrl_q, `SWC_CTRL_MCLREN_BIT)
                       || i_bor_trip && bitv(ctrl_q, `SWC_CTRL_BOREN_BIT)
                       || i_low_power_brownout_reset_trip || i_por
                       || i_wdt_expire && bitv(ctrl_q, `SWC_CTRL_WDTEN_BIT);
    assign wake_irq    = (state_q == SWC_SLEEP) && irq_pending;
    assign ev_wake     = (state_q == SWC_SLEEP) && (irq_pending || reset_wake);
    assign ev_switch   = (state_q == SWC_SWITCHING) && (sw_cnt_q == 8'h01)
                       && !bitv(ctrl_q, `SWC_CTRL_HOLD_BIT) && !i_sleep_exec;
    assign ev_nop_sleep = i_sleep_exec && irq_pending
                       && (state_q == SWC_RUN || state_q == SWC_SWITCHING);

    swc_ready_gate u_ready (
        .i_clk         (i_clk),
        .i_rstn        (i_rstn),
        .i_flash_ready (i_flash_ready),
        .i_osc_ready   (i_osc_ready),
        .i_bor_ready   (i_bor_ready),
        .i_bor_enable  (bitv(ctrl_q, `SWC_CTRL_BOREN_BIT)),
        .o_all_ready   (all_ready)
    );

    // Main sequence
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q      <= SWC_RUN;
            sw_cnt_q     <= 8'h00;
            sw_pending_q <= 1'b0;
            rst_wake_q   <= 1'b0;
            osc_cur_q    <= `SWC_OSC_RST;
        end else begin
            case (state_q)
                SWC_RUN: begin
                    if (i_sleep_exec && !irq_pending) begin
                        state_q <= SWC_SLEEP;
                    end else if (wr_osc && i_wdata[2:0] != osc_cur_q) begin
                        state_q  <= SWC_SWITCHING;
                        sw_cnt_q <= SWITCH_CYCLES[7:0];
                    end
                end
                SWC_SWITCHING: begin
                    if (i_sleep_exec && !irq_pending) begin
                        // Pending switch is dropped; the request is kept for the wake decision
                        state_q      <= SWC_SLEEP;
                        sw_pending_q <= 1'b1;
                    end else if (sw_cnt_q == 8'h01) begin
                        if (!bitv(ctrl_q, `SWC_CTRL_HOLD_BIT)) begin
                            osc_cur_q <= osc_req_q;
                            state_q   <= SWC_RUN;
                        end
                    end else begin
                        sw_cnt_q <= sw_cnt_q - 8'h01;
                    end
                end
                SWC_SLEEP: begin
                    if (reset_wake) begin
                        // Reset wakes also wait for readiness before the core runs
                        state_q      <= SWC_READY_WAIT;
                        rst_wake_q   <= 1'b1;
                        sw_pending_q <= 1'b0;
                    end else if (irq_pending) begin
                        state_q <= SWC_READY_WAIT;
                        if (sw_pending_q && !bitv(ctrl_q, `SWC_CTRL_HOLD_BIT)) begin
                            osc_cur_q    <= osc_req_q;
                            sw_pending_q <= 1'b0;
                        end
                    end
                end
                SWC_READY_WAIT: begin
                    if (all_ready) begin
                        if (rst_wake_q) begin
                            state_q    <= SWC_RUN;
                            rst_wake_q <= 1'b0;
                        end else if (bitv(ctrl_q, `SWC_CTRL_GIE_BIT)) begin
                            // Vector first; a held switch is requested again afterwards
                            state_q <= SWC_VECTOR;
                        end else if (sw_pending_q) begin
                            // Old clock kept, new one asked for again
                            state_q      <= SWC_SWITCHING;
                            sw_cnt_q     <= SWITCH_CYCLES[7:0];
                            sw_pending_q <= 1'b0;
                        end else begin
                            state_q <= SWC_RUN;
                        end
                    end
                end
                SWC_VECTOR: begin
                    if (sw_pending_q) begin
                        state_q      <= SWC_SWITCHING;
                        sw_cnt_q     <= SWITCH_CYCLES[7:0];
                        sw_pending_q <= 1'b0;
                    end else begin
                        state_q <= SWC_RUN;
                    end
                end
                default: begin
                    state_q <= SWC_RUN;
                end
            endcase
        end
    end

    // Peripheral event flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_q <= `SWC_FLAGS_RST;
        end else if (wr_flags) begin
            flags_q <= (flags_q & i_wdata) | i_event;
        end else begin
            flags_q <= flags_q | i_event;
        end
    end

    // Software registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enable_q   <= 8'h00;
            osc_req_q  <= `SWC_OSC_RST;
            ctrl_q     <= 8'h00;
            irq_mask_q <= 3'h0;
        end else if (i_wr) begin
            if (i_addr == `SWC_OFF_ENABLE)   enable_q   <= i_wdata;
            if (wr_osc)                      osc_req_q  <= i_wdata[2:0];
            if (i_addr == `SWC_OFF_CTRL)     ctrl_q     <= {3'h0, i_wdata[4:0]};
            if (i_addr == `SWC_OFF_IRQ_MASK) irq_mask_q <= i_wdata[2:0];
        end
    end

    // Timeout, power-down and switch done flag
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            to_q      <= 1'b1;
            pd_q      <= 1'b1;
            sw_done_q <= 1'b0;
        end else begin
            if (i_sleep_exec && !irq_pending && (state_q == SWC_RUN || state_q == SWC_SWITCHING)) begin
                pd_q <= 1'b0;
            end
            if (wake_irq) begin
                to_q <= 1'b1;
                pd_q <= 1'b0;
            end
            if ((wake_irq && sw_pending_q && !bitv(ctrl_q, `SWC_CTRL_HOLD_BIT)) || ev_switch) begin
                sw_done_q <= 1'b1;
            end else if (i_wr && i_addr == `SWC_OFF_STATUS && !i_wdata[`SWC_ST_DONE_BIT]) begin
                sw_done_q <= 1'b0;
            end
        end
    end

    // Event status: read clears, but an event in the same cycle survives
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= (rd_irq ? 3'h0 : irq_stat_q) | {ev_nop_sleep, ev_switch, ev_wake};
        end
    end

    // Outputs, all registered
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata         <= 8'h00;
            o_sleeping      <= 1'b0;
            o_core_run      <= 1'b0;
            o_vector_req    <= 1'b0;
            o_reset_req     <= 1'b0;
            o_wdt_clear     <= 1'b0;
            o_prefetch_pc   <= '0;
            o_prefetch_req  <= 1'b0;
            o_clk_sel       <= `SWC_OSC_RST;
            o_new_osc_ready <= 1'b0;
            o_irq           <= 1'b0;
        end else begin
            o_sleeping      <= (state_q == SWC_SLEEP);
            o_core_run      <= (state_q == SWC_RUN || state_q == SWC_SWITCHING || state_q == SWC_VECTOR);
            o_vector_req    <= (state_q == SWC_VECTOR);
            o_reset_req     <= (state_q == SWC_SLEEP) && reset_wake;
            // Wakes of every kind clear the watchdog; a no-operation sleep does not
            o_wdt_clear     <= ev_wake;
            o_prefetch_req  <= i_sleep_exec && !irq_pending;
            if (i_sleep_exec) begin
                o_prefetch_pc <= i_pc + PC_W'(`SWC_PC_STEP);
            end
            o_clk_sel       <= osc_cur_q;
            o_new_osc_ready <= ev_switch;
            o_irq           <= |(irq_stat_q & irq_mask_q);
            o_rdata         <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `SWC_OFF_FLAGS:    o_rdata <= flags_q;
                    `SWC_OFF_ENABLE:   o_rdata <= enable_q;
                    `SWC_OFF_OSCSEL:   o_rdata <= {5'h00, osc_req_q};
                    `SWC_OFF_CTRL:     o_rdata <= ctrl_q;
                    `SWC_OFF_STATUS:   o_rdata <= {5'h00, sw_done_q, pd_q, to_q};
                    `SWC_OFF_IRQ_STAT: o_rdata <= {5'h00, irq_stat_q};
                    `SWC_OFF_IRQ_MASK: o_rdata <= {5'h00, irq_mask_q};
                    default:           o_rdata <= 8'h00;
                endcase
            end
        end
    end

    no_op_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_sleep_exec && irq_pending && state_q == SWC_RUN) |=> (state_q != SWC_SLEEP) && $stable(pd_q))
        else $error("sleep with pending interrupt did not act as no-op");
    irq_wake_flags_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wake_irq && !reset_wake) |=> to_q && !pd_q && state_q == SWC_READY_WAIT)
        else $error("interrupt wake did not set timeout and clear power-down");
    wake_wdt_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ev_wake |=> o_wdt_clear)
        else $error("watchdog not cleared on wake");
    sleep_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == SWC_SLEEP && !irq_pending && !reset_wake) |=> state_q == SWC_SLEEP)
        else $error("left sleep without a wake source");
    ready_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == SWC_READY_WAIT && !all_ready) |=> state_q == SWC_READY_WAIT)
        else $error("resumed before readiness");
    flag_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (|i_event) |=> ((flags_q & $past(i_event)) == $past(i_event)))
        else $error("event flag not set");
    vector_gie_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == SWC_READY_WAIT && all_ready && !sw_pending_q && !bitv(ctrl_q, `SWC_CTRL_GIE_BIT))
        |=> state_q == SWC_RUN ##1 !o_vector_req)
        else $error("vectored with global enable off");
    osc_ready_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_new_osc_ready |=> !o_new_osc_ready)
        else $error("new oscillator ready longer than the switch");
    prefetch_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_sleep_exec |=> o_prefetch_pc == $past(i_pc) + PC_W'(`SWC_PC_STEP))
        else $error("prefetch address not pc plus two");
    abandon_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == SWC_SWITCHING && i_sleep_exec && !irq_pending) |=> state_q == SWC_SLEEP && $stable(osc_cur_q))
        else $error("switch completed instead of being abandoned");
endmodule : swc_ctrl
`default_nettype wire

// ===== verification/swc_ready_model.sv
// Readiness model of the flash, oscillator and brown-out logic that surround the controller
`timescale 1ns/1ps
`default_nettype none
module swc_ready_model (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_sleeping,
    input  wire logic i_slow,
    output logic      o_flash_ready,
    output logic      o_osc_ready,
    output logic      o_bor_ready
);
    logic [4:0] cnt_q;

    // All three drop in sleep and come back staggered in slow mode, so each ready input is exercised alone
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 5'h1f;
        end else if (i_sleeping) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    assign o_flash_ready = cnt_q >= (i_slow ? 5'h04 : 5'h01);
    assign o_osc_ready   = cnt_q >= (i_slow ? 5'h08 : 5'h01);
    assign o_bor_ready   = cnt_q >= (i_slow ? 5'h0c : 5'h01);
endmodule : swc_ready_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking testbench of the sleep and wake controller
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module testbench;
    logic        i_clk, i_rstn, i_wr, i_rd, i_sleep_exec, slow, boren, run_q;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata, i_event, o_rdata, d;
    logic [15:0] i_pc, o_prefetch_pc;
    logic [4:0]  rsrc;
    logic [2:0]  o_clk_sel;
    logic        rdy_f, rdy_o, rdy_b, o_sleeping, o_core_run, o_vector_req, o_reset_req;
    logic        o_wdt_clear, o_prefetch_req, o_new_osc_ready, o_irq;
    int          fails, n_tests, n_wdt, n_vec, n_rst, n_nosc, n_pf, n_slp, k;

    swc_ctrl #(.SWITCH_CYCLES(4), .PC_W(16)) uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_sleep_exec(i_sleep_exec), .i_pc(i_pc), .i_event(i_event),
        .i_reset_pin(rsrc[4]), .i_bor_trip(rsrc[3]), .i_low_power_brownout_reset_trip(rsrc[2]), .i_por(rsrc[1]),
        .i_wdt_expire(rsrc[0]), .i_flash_ready(rdy_f), .i_osc_ready(rdy_o), .i_bor_ready(rdy_b),
        .o_sleeping(o_sleeping), .o_core_run(o_core_run), .o_vector_req(o_vector_req),
        .o_reset_req(o_reset_req), .o_wdt_clear(o_wdt_clear), .o_prefetch_pc(o_prefetch_pc),
        .o_prefetch_req(o_prefetch_req), .o_clk_sel(o_clk_sel), .o_new_osc_ready(o_new_osc_ready),
        .o_irq(o_irq));
    swc_ready_model partner (.i_clk(i_clk), .i_rstn(i_rstn), .i_sleeping(o_sleeping), .i_slow(slow),
        .o_flash_ready(rdy_f), .o_osc_ready(rdy_o), .o_bor_ready(rdy_b));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(v, e);
    endtask : rdc
    task automatic pulse(input logic [7:0] e, input logic [4:0] r);
        @(posedge i_clk);
        i_event <= e; rsrc <= r;
        @(posedge i_clk);
        i_event <= 8'h00; rsrc <= 5'h00;
    endtask : pulse
    task automatic slp(input logic [15:0] pc);
        n_wdt = 0; n_vec = 0; n_rst = 0; n_nosc = 0; n_pf = 0; n_slp = 0;
        @(posedge i_clk);
        i_sleep_exec <= 1'b1; i_pc <= pc;
        @(posedge i_clk);
        i_sleep_exec <= 1'b0;
    endtask : slp
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : idle
    // Bounded so a wake that never completes is reported instead of hanging
    task automatic wait_run;
        int j;
        j = 0;
        while (o_core_run !== 1'b1 && j < 200) begin
            idle(1);
            j++;
        end
        check(j < 200, 1'b1);
    endtask : wait_run

    always @(posedge i_clk) begin
        n_wdt  <= n_wdt + int'(o_wdt_clear);
        n_vec  <= n_vec + int'(o_vector_req);
        n_rst  <= n_rst + int'(o_reset_req);
        n_nosc <= n_nosc + int'(o_new_osc_ready);
        n_pf   <= n_pf + int'(o_prefetch_req);
        n_slp  <= n_slp + int'(o_sleeping);
    end
    always @(posedge i_clk) begin
        #1;
        if (o_core_run === 1'b1 && run_q === 1'b0) check(rdy_f & rdy_o & (rdy_b | !boren), 1'b1);
        run_q = o_core_run;
    end

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        wrap_up();
    end
    initial begin
        {i_wr, i_rd, i_sleep_exec, slow, boren} = 5'h00;
        i_rstn = 1'b0; i_addr = 4'h0; i_wdata = 8'h00; i_pc = 16'h0000; i_event = 8'h00; rsrc = 5'h00;
        fails = 0; n_tests = 0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        rdc(`SWC_OFF_STATUS, 8'h03);
        rdc(`SWC_OFF_FLAGS, `SWC_FLAGS_RST);
        wr(4'hf, 8'hff);
        rdc(4'hf, 8'h00);
        check(o_clk_sel, `SWC_OSC_RST);
        for (k = 0; k < 8; k++) begin
            pulse(8'h01 << k, 5'h00);
            rdc(`SWC_OFF_FLAGS, 8'h01 << k);
            wr(`SWC_OFF_FLAGS, 8'hff);
            rdc(`SWC_OFF_FLAGS, 8'h01 << k);
            wr(`SWC_OFF_FLAGS, 8'h00);
            rdc(`SWC_OFF_FLAGS, 8'h00);
        end
        // Oscillator change still pending when sleep starts, woken by the comparator flag
        wr(`SWC_OFF_ENABLE, 8'h08);
        wr(`SWC_OFF_IRQ_MASK, 8'h01);
        wr(`SWC_OFF_OSCSEL, 8'h05);
        slp(16'h0100);
        idle(3);
        check(o_sleeping, 1'b1);
        check(o_clk_sel, 3'h0);
        check(o_prefetch_pc, 16'h0102);
        check(n_pf, 1);
        pulse(8'h08, 5'h00);
        wait_run();
        idle(4);
        check(o_clk_sel, 3'h5);
        check(n_wdt, 1);
        check(n_vec, 0);
        check(n_rst, 0);
        check(o_irq, 1'b1);
        rd(`SWC_OFF_IRQ_STAT, d);
        check(d & 8'h01, 8'h01);
        idle(1);
        check(o_irq, 1'b0);
        rdc(`SWC_OFF_STATUS, 8'h05);
        wr(`SWC_OFF_FLAGS, 8'h00);
        // Enabled flag already pending: sleep must fall through
        pulse(8'h08, 5'h00);
        wr(`SWC_OFF_IRQ_MASK, 8'h04);
        slp(16'h0200);
        idle(4);
        check(n_slp, 0);
        check(n_wdt, 0);
        check(n_pf, 0);
        rdc(`SWC_OFF_STATUS, 8'h05);
        check(o_irq, 1'b1);
        rd(`SWC_OFF_IRQ_STAT, d);
        check(d & 8'h04, 8'h04);
        wr(`SWC_OFF_FLAGS, 8'h00);
        wr(`SWC_OFF_STATUS, 8'h00);
        wr(`SWC_OFF_IRQ_MASK, 8'h00);
        // Hold set, global enable set, slow readiness, flag raised before its enable
        slow <= 1'b1;
        boren <= 1'b1;
        wr(`SWC_OFF_CTRL, 8'h07);
        wr(`SWC_OFF_ENABLE, 8'h00);
        wr(`SWC_OFF_OSCSEL, 8'h03);
        slp(16'h0300);
        idle(3);
        pulse(8'h04, 5'h00);
        idle(8);
        check(o_sleeping, 1'b1);
        check(n_wdt, 0);
        wr(`SWC_OFF_ENABLE, 8'h04);
        wait_run();
        check(o_clk_sel, 3'h5);
        wr(`SWC_OFF_CTRL, 8'h06);
        for (k = 0; k < 60 && n_nosc == 0; k++) idle(1);
        check(o_clk_sel, 3'h3);
        check(n_nosc, 1);
        check(n_vec, 1);
        check(n_wdt, 1);
        slow <= 1'b0;
        wr(`SWC_OFF_FLAGS, 8'h00);
        wr(`SWC_OFF_ENABLE, 8'h00);
        // Every reset source ends sleep with a reset request
        for (k = 0; k < 5; k++) begin
            wr(`SWC_OFF_CTRL, 8'h1c);
            slp(16'h0400);
            idle(3);
            pulse(8'h00, 5'h01 << k);
            wait_run();
            idle(2);
            check(n_rst, 1);
            check(n_wdt, 1);
        end
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
